// [sps_pkg.sv]
package sps_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] ADDR_CTRL        = 8'h00;
  localparam logic [7:0] ADDR_STATUS      = 8'h04;
  localparam logic [7:0] ADDR_ERR_TIME    = 8'h08;
  localparam logic [7:0] ADDR_DRIFT       = 8'h0c;
  localparam logic [7:0] ADDR_S2_MODE     = 8'h10;
  localparam logic [7:0] ADDR_S2_MULDIV   = 8'h14;
  localparam logic [7:0] ADDR_S2_POSDRIFT = 8'h18;
  localparam logic [7:0] ADDR_S2_SENSE    = 8'h1c;
  localparam logic [7:0] ADDR_S2_PHASE    = 8'h20;
  localparam logic [7:0] ADDR_S2_SETFREQ  = 8'h24;
  localparam logic [7:0] ADDR_S2_MISC     = 8'h28;
  localparam logic [7:0] ADDR_ACTIVE_THR  = 8'h2c;
  localparam logic [7:0] ADDR_THR_BASE    = 8'h40;

  // ****************************************************************
  // Control register fields
  // ****************************************************************
  localparam int CTRL_IM1_LSB    = 0;
  localparam int CTRL_IM2_LSB    = 2;
  localparam int CTRL_CNT_LSB    = 4;
  localparam int CTRL_TOGGLE_BIT = 8;
  localparam int CTRL_TSRC_BIT   = 9;
  localparam int CTRL_SWM_LSB    = 16;

  // ****************************************************************
  // Settings and reset values
  // ****************************************************************
  localparam logic [1:0] INPUT_MODE_MULTI = 2'h3;
  localparam logic [2:0] CNT_A_FOUR       = 3'h1;
  localparam logic [2:0] CNT_B_FOUR       = 3'h3;
  localparam logic [2:0] CNT_B_SIXTEEN    = 3'h4;
  localparam logic [4:0] SWM_DRIFT_A      = 5'h11;
  localparam logic [4:0] SWM_DRIFT_B      = 5'h12;
  localparam logic [31:0] THR_ODD_RST     = 32'h000186a0;
  localparam logic [31:0] THR_EVEN_RST    = 32'h00030d40;
  localparam logic [31:0] THR_MAX         = 32'h02faf080;
  localparam logic [1:0] S2_OPMODE_RST    = 2'h1;
  localparam logic [13:0] S2_MUL_RST      = 14'h0001;
  localparam logic [13:0] S2_DIV_RST      = 14'h0001;
  localparam logic [11:0] S2_SENSE_RST    = 12'h960;
  localparam logic [11:0] S2_TOL_RST      = 12'h064;
  localparam logic [9:0] S2_PHASE_RST     = 10'h00a;
  localparam logic [2:0] S2_EMASK_RST     = 3'h3;
  localparam logic [15:0] ERR_TIME_MS_RST = 16'h0064;
  localparam int CLK_HZ                   = 10_000_000;
  localparam int CYC_PER_MS               = CLK_HZ / 1000;

  typedef struct packed {
    logic [1:0]  op_mode;
    logic        edge_sel;
    logic        dir;
    logic [13:0] mul;
    logic [13:0] div;
    logic [16:0] pos_drift;
    logic [11:0] sense;
    logic [11:0] tol;
    logic [9:0]  phase_err;
    logic [31:0] set_freq;
    logic [2:0]  err_mask;
    logic [13:0] dir_changes;
  } sps_sensor_t;

endpackage

// [sps_gray_dec.sv]
`timescale 1ns/1ps
module sps_gray_dec (
  // Gray input
  input  wire logic [3:0] gray,
  // Binary output
  output logic [3:0]      bin
);
  always_comb begin
    bin[3] = gray[3];
    for (int i = 2; i >= 0; i--) begin
      bin[i] = bin[i+1] ^ gray[i];
    end
  end
endmodule

// [sps_selector.sv]
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module sps_selector #(
  parameter int N_OUT    = 5,
  parameter int N_THR    = 16,
  parameter int TIMER_W  = 24
) (
  // Clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  // Control input pins
  input  wire logic [1:0]           ctrl_input_group_a,
  input  wire logic [1:0]           ctrl_input_group_b,
  input  wire logic                 toggle_in,
  // Selection outputs
  output logic [N_OUT-1:0][31:0]    threshold_out,
  output logic [3:0]                sel_index,
  output logic                      sel_error,
  output logic [13:0]               out_a_max_drift,
  output logic                      drift_active,
  output sps_pkg::sps_sensor_t      sensor_b_cfg
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [N_OUT*N_THR-1:0][31:0] thr;
    logic [1:0]                   im1;
    logic [1:0]                   im2;
    logic [2:0]                   cnt;
    logic                         toggle_en;
    logic [4:0]                   swm;
    logic [15:0]                  err_ms;
    logic [13:0]                  drift;
    sps_pkg::sps_sensor_t         s2;
    logic [1:0]                   a_s1;
    logic [1:0]                   a_s2;
    logic [1:0]                   b_s1;
    logic [1:0]                   b_s2;
    logic                         t_s1;
    logic                         t_s2;
    logic [3:0]                   idx;
    logic [TIMER_W-1:0]           timer;
    logic                         err;
    logic                         aw_got;
    logic [7:0]                   aw_addr;
    logic                         w_got;
    logic [31:0]                  w_data;
    logic [3:0]                   w_strb;
    logic                         bvalid;
    logic                         rvalid;
    logic [31:0]                  rdata;
    logic [1:0]                   rresp;
    logic [1:0]                   bresp;
  } sps_state_t;

  sps_state_t s_r;
  sps_state_t s_nxt;

  logic [3:0] group_bin;
  logic [3:0] raw_code;

  // The group that drives four-point selection goes through the Gray decoder
  assign raw_code = {(s_r.im2 == sps_pkg::INPUT_MODE_MULTI) ? s_r.b_s2 : s_r.a_s2, 2'h0};

  sps_gray_dec u_gray (
    .gray (raw_code),
    .bin  (group_bin)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        wr_fire;
    logic        wr_ok;
    logic [31:0] wv;
    logic [7:0]  wa;
    logic [7:0]  ra;
    logic [6:0]  ti;
    logic        multi;
    logic        four;
    logic [3:0]  want;
    logic        invalid;
    s_nxt   = s_r;
    wr_fire = 1'b0;
    wr_ok   = 1'b0;
    wv      = 32'h0;
    wa      = 8'h0;
    ra      = 8'h0;
    ti      = 7'h0;
    multi   = 1'b0;
    four    = 1'b0;
    want    = s_r.idx;
    invalid = 1'b0;

    // Pin synchronisers; stage one feeds only stage two
    s_nxt.a_s1 = ctrl_input_group_a;
    s_nxt.a_s2 = s_r.a_s1;
    s_nxt.b_s1 = ctrl_input_group_b;
    s_nxt.b_s2 = s_r.b_s1;
    s_nxt.t_s1 = toggle_in;
    s_nxt.t_s2 = s_r.t_s1;

    // Write channel
    if (s_axi_awvalid && !s_r.aw_got) begin
      s_nxt.aw_got  = 1'b1;
      s_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got) begin
      s_nxt.w_got  = 1'b1;
      s_nxt.w_data = s_axi_wdata;
      s_nxt.w_strb = s_axi_wstrb;
    end
    if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
      wr_fire      = 1'b1;
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    wa = s_r.aw_addr;
    wv = s_r.w_data;
    // Only full-word writes are accepted; partial words would split a threshold
    if (wr_fire) begin
      wr_ok = (s_r.w_strb == 4'hf);
      if (!wr_ok) begin
        wr_ok = 1'b0;
      end else if (wa == sps_pkg::ADDR_CTRL) begin
        s_nxt.im1       = wv[sps_pkg::CTRL_IM1_LSB +: 2];
        s_nxt.im2       = wv[sps_pkg::CTRL_IM2_LSB +: 2];
        s_nxt.cnt       = wv[sps_pkg::CTRL_CNT_LSB +: 3];
        s_nxt.toggle_en = wv[sps_pkg::CTRL_TOGGLE_BIT];
        s_nxt.swm       = wv[sps_pkg::CTRL_SWM_LSB +: 5];
      end else if (wa == sps_pkg::ADDR_ERR_TIME) begin
        s_nxt.err_ms = wv[15:0];
      end else if (wa == sps_pkg::ADDR_DRIFT) begin
        s_nxt.drift = wv[13:0];
      end else if (wa == sps_pkg::ADDR_S2_MODE) begin
        s_nxt.s2.op_mode  = wv[1:0];
        s_nxt.s2.edge_sel = wv[4];
        s_nxt.s2.dir      = wv[8];
      end else if (wa == sps_pkg::ADDR_S2_MULDIV) begin
        s_nxt.s2.mul = wv[13:0];
        s_nxt.s2.div = wv[29:16];
      end else if (wa == sps_pkg::ADDR_S2_POSDRIFT) begin
        s_nxt.s2.pos_drift = wv[16:0];
      end else if (wa == sps_pkg::ADDR_S2_SENSE) begin
        s_nxt.s2.sense = wv[11:0];
        s_nxt.s2.tol   = wv[27:16];
      end else if (wa == sps_pkg::ADDR_S2_PHASE) begin
        s_nxt.s2.phase_err = wv[9:0];
      end else if (wa == sps_pkg::ADDR_S2_SETFREQ) begin
        s_nxt.s2.set_freq = wv;
      end else if (wa == sps_pkg::ADDR_S2_MISC) begin
        s_nxt.s2.err_mask    = wv[2:0];
        s_nxt.s2.dir_changes = wv[29:16];
      end else if (wa >= sps_pkg::ADDR_THR_BASE) begin
        ti = 7'(wa[7:2] - sps_pkg::ADDR_THR_BASE[7:2]);
        if (ti < 7'(N_OUT*N_THR)) begin
          // Values outside +-500000.00 Hz are refused
          if ($signed(wv) <= $signed(sps_pkg::THR_MAX)
              && $signed(wv) >= -$signed(sps_pkg::THR_MAX)) begin
            s_nxt.thr[ti] = wv;
          end else begin
            wr_ok = 1'b0;
          end
        end else begin
          wr_ok = 1'b0;
        end
      end else begin
        wr_ok = 1'b0;
      end
      s_nxt.bresp = wr_ok ? 2'h0 : 2'h2;
    end

    // Read channel
    if (s_axi_arvalid && !s_r.rvalid) begin
      ra           = s_axi_araddr;
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp  = 2'h0;
      s_nxt.rdata  = 32'h0;
      if (ra == sps_pkg::ADDR_CTRL) begin
        s_nxt.rdata[sps_pkg::CTRL_IM1_LSB +: 2] = s_r.im1;
        s_nxt.rdata[sps_pkg::CTRL_IM2_LSB +: 2] = s_r.im2;
        s_nxt.rdata[sps_pkg::CTRL_CNT_LSB +: 3] = s_r.cnt;
        s_nxt.rdata[sps_pkg::CTRL_TOGGLE_BIT]   = s_r.toggle_en;
        s_nxt.rdata[sps_pkg::CTRL_SWM_LSB +: 5] = s_r.swm;
      end else if (ra == sps_pkg::ADDR_STATUS) begin
        s_nxt.rdata[3:0] = s_r.idx;
        s_nxt.rdata[8]   = s_r.err;
      end else if (ra == sps_pkg::ADDR_ERR_TIME) begin
        s_nxt.rdata[15:0] = s_r.err_ms;
      end else if (ra == sps_pkg::ADDR_DRIFT) begin
        s_nxt.rdata[13:0] = s_r.drift;
      end else if (ra == sps_pkg::ADDR_S2_MODE) begin
        s_nxt.rdata[1:0] = s_r.s2.op_mode;
        s_nxt.rdata[4]   = s_r.s2.edge_sel;
        s_nxt.rdata[8]   = s_r.s2.dir;
      end else if (ra == sps_pkg::ADDR_S2_MULDIV) begin
        s_nxt.rdata = {2'h0, s_r.s2.div, 2'h0, s_r.s2.mul};
      end else if (ra == sps_pkg::ADDR_S2_POSDRIFT) begin
        s_nxt.rdata[16:0] = s_r.s2.pos_drift;
      end else if (ra == sps_pkg::ADDR_S2_SENSE) begin
        s_nxt.rdata = {4'h0, s_r.s2.tol, 4'h0, s_r.s2.sense};
      end else if (ra == sps_pkg::ADDR_S2_PHASE) begin
        s_nxt.rdata[9:0] = s_r.s2.phase_err;
      end else if (ra == sps_pkg::ADDR_S2_SETFREQ) begin
        s_nxt.rdata = s_r.s2.set_freq;
      end else if (ra == sps_pkg::ADDR_S2_MISC) begin
        s_nxt.rdata = {2'h0, s_r.s2.dir_changes, 13'h0, s_r.s2.err_mask};
      end else if (ra == sps_pkg::ADDR_ACTIVE_THR) begin
        s_nxt.rdata = s_r.thr[s_r.idx];
      end else if (ra >= sps_pkg::ADDR_THR_BASE
                   && 7'(ra[7:2] - sps_pkg::ADDR_THR_BASE[7:2]) < 7'(N_OUT*N_THR)) begin
        s_nxt.rdata = s_r.thr[7'(ra[7:2] - sps_pkg::ADDR_THR_BASE[7:2])];
      end else begin
        s_nxt.rresp = 2'h2;
      end
    end
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end

    // ****************************************************************
    // Threshold index selection; the pins move it, and with no mode set it is forced to 0
    // ****************************************************************
    if (s_r.im2 == sps_pkg::INPUT_MODE_MULTI) begin
      if (s_r.cnt == sps_pkg::CNT_B_FOUR) begin
        multi = 1'b1;
        four  = 1'b1;
        want  = {2'h0, group_bin[3:2]};
      end else if (s_r.cnt == sps_pkg::CNT_B_SIXTEEN) begin
        multi = 1'b1;
        want  = {s_r.a_s2, s_r.b_s2};
      end
    end else if (s_r.im1 == sps_pkg::INPUT_MODE_MULTI) begin
      if (s_r.cnt == sps_pkg::CNT_A_FOUR) begin
        multi = 1'b1;
        four  = 1'b1;
        want  = {2'h0, group_bin[3:2]};
      end
    end
    // Four-point code: a jump of two steps is a non-adjacent, invalid change
    if (four) begin
      invalid = (want[1:0] != s_r.idx[1:0])
                && (want[1:0] - s_r.idx[1:0] == 2'h2);
    end
    if (multi && !invalid) begin
      s_nxt.idx   = want;
      s_nxt.timer = '0;
    end else if (multi && invalid) begin
      // Hold previous index while counting the error time
      if (s_r.timer >= TIMER_W'(s_r.err_ms) * TIMER_W'(sps_pkg::CYC_PER_MS)) begin
        s_nxt.err = 1'b1;
      end else begin
        s_nxt.timer = s_r.timer + TIMER_W'(1);
      end
    end else if (s_r.toggle_en && s_r.im1 != 2'h0 && s_r.im1 != 2'h3
                 && s_r.im2 != 2'h0 && s_r.im2 != 2'h3) begin
      s_nxt.idx   = {3'h0, s_r.t_s2};
      s_nxt.timer = '0;
    end else begin
      s_nxt.idx   = 4'h0;
      s_nxt.timer = '0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= '0;
      for (int o = 0; o < N_OUT; o++) begin
        for (int k = 0; k < N_THR; k++) begin
          s_r.thr[o*N_THR+k] <= k[0] ? sps_pkg::THR_EVEN_RST : sps_pkg::THR_ODD_RST;
        end
      end
      s_r.err_ms         <= sps_pkg::ERR_TIME_MS_RST;
      s_r.s2.op_mode     <= sps_pkg::S2_OPMODE_RST;
      s_r.s2.mul         <= sps_pkg::S2_MUL_RST;
      s_r.s2.div         <= sps_pkg::S2_DIV_RST;
      s_r.s2.sense       <= sps_pkg::S2_SENSE_RST;
      s_r.s2.tol         <= sps_pkg::S2_TOL_RST;
      s_r.s2.phase_err   <= sps_pkg::S2_PHASE_RST;
      s_r.s2.err_mask    <= sps_pkg::S2_EMASK_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < N_OUT; g++) begin : g_out
      // Raw threshold, never scaled by multiplier or divisor
      assign threshold_out[g] = s_r.thr[g*N_THR + int'(s_r.idx)];
    end
  endgenerate

  assign sel_index       = s_r.idx;
  assign sel_error       = s_r.err;
  assign out_a_max_drift = s_r.drift;
  assign drift_active    = (s_r.swm == sps_pkg::SWM_DRIFT_A)
                           || (s_r.swm == sps_pkg::SWM_DRIFT_B);
  assign sensor_b_cfg    = s_r.s2;

  assign s_axi_awready = !s_r.aw_got;
  assign s_axi_wready  = !s_r.w_got;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rdata   = s_r.rdata;
  assign s_axi_rresp   = s_r.rresp;

endmodule

// [sps_selector_assertions.sv]
`timescale 1ns/1ps
module sps_chk #(
  parameter int N_OUT = 5
) (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Register bus
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic [1:0]              s_axi_bresp,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_bready,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic [31:0]             s_axi_rdata,
  input wire logic [1:0]              s_axi_rresp,
  input wire logic                    s_axi_rvalid,
  input wire logic                    s_axi_rready,
  // Selection
  input wire logic [N_OUT-1:0][31:0]  threshold_out,
  input wire logic [3:0]              sel_index,
  input wire logic                    sel_error
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  property p_b_after; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_r_after; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");
  property p_b_hold; s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_bresp; s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
  a_bresp: assert property (p_bresp) else $error("bad write response code");
  property p_rresp; s_axi_rvalid |-> s_axi_rresp == 2'h0 || s_axi_rresp == 2'h2; endproperty
  a_rresp: assert property (p_rresp) else $error("bad read response code");
  property p_ar_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
  property p_reset_vals;
    $rose(aresetn) |-> sel_index == 4'h0 && !sel_error && threshold_out[0] == sps_pkg::THR_ODD_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("bad state after reset");
  property p_err_sticky; sel_error |=> sel_error; endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("input error cleared");
endmodule
bind sps_selector sps_chk #(.N_OUT(N_OUT)) u_chk (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .threshold_out, .sel_index, .sel_error);

// [sps_ctl_model.sv]
`timescale 1ns/1ps
module sps_ctl_model (
  // Clock
  input wire logic        aclk,
  // Command: 0 toggle, 1 Gray on a, 2 Gray on b, 3 raw on a and b
  input wire logic [1:0]  mode,
  input wire logic [3:0]  code,
  input wire logic [3:0]  lag,
  // Control pins
  output logic [1:0]      ctrl_input_group_a,
  output logic [1:0]      ctrl_input_group_b,
  output logic            toggle_in
);
  logic [5:0] cmd_r = 6'h00;
  logic [3:0] cnt_r = 4'h0;
  initial {ctrl_input_group_a, ctrl_input_group_b, toggle_in} = 5'h00;
  // A slow controller holds the old levels for lag + 1 cycles after it sees a new command
  always @(posedge aclk) begin
    if ({mode, code} != cmd_r) begin
      cmd_r <= {mode, code};
      cnt_r <= lag;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else begin
      case (mode)
        2'h0: {ctrl_input_group_a, ctrl_input_group_b, toggle_in} <= {4'h0, code[0]};
        2'h1: {ctrl_input_group_a, ctrl_input_group_b, toggle_in} <= {code[1], code[1] ^ code[0], 3'h0};
        2'h2: {ctrl_input_group_a, ctrl_input_group_b, toggle_in} <= {2'h0, code[1], code[1] ^ code[0], 1'b0};
        default: {ctrl_input_group_a, ctrl_input_group_b, toggle_in} <= {code, 1'b0};
      endcase
    end
  end
endmodule

// [speed_threshold_preset_selector_test.sv]
`timescale 1ns/1ps
module speed_threshold_preset_selector_test;
  // ********
  // Signals
  // ********
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                  s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic                  s_axi_rready, toggle_in, sel_error, drift_active;
  logic [7:0]            s_axi_awaddr, s_axi_araddr;
  logic [31:0]           s_axi_wdata, s_axi_rdata, seed, rd, v, exp_thr [5][16];
  logic [3:0]            s_axi_wstrb, sel_index, code, lag;
  logic [1:0]            s_axi_bresp, s_axi_rresp, ctrl_input_group_a, ctrl_input_group_b, mode, rsp;
  logic [4:0][31:0]      threshold_out;
  logic [13:0]           out_a_max_drift;
  sps_pkg::sps_sensor_t  sensor_b_cfg;
  int                    n_errors, checks_done, i, k;
  logic [7:0]            ra [9] = '{sps_pkg::ADDR_S2_MODE, sps_pkg::ADDR_S2_MULDIV,
    sps_pkg::ADDR_S2_SENSE, sps_pkg::ADDR_S2_PHASE, sps_pkg::ADDR_S2_MISC,
    sps_pkg::ADDR_ERR_TIME, sps_pkg::ADDR_DRIFT, sps_pkg::ADDR_S2_POSDRIFT,
    sps_pkg::ADDR_S2_SETFREQ};
  logic [31:0]           rv [9] = '{32'h1, 32'h10001, 32'h640960, 32'ha, 32'h3, 32'h64, 32'h0,
    32'h0, 32'h0};

  sps_selector uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ctrl_input_group_a, .ctrl_input_group_b, .toggle_in, .threshold_out,
    .sel_index, .sel_error, .out_a_max_drift, .drift_active, .sensor_b_cfg);
  sps_ctl_model ctl (.aclk, .mode, .code, .lag, .ctrl_input_group_a, .ctrl_input_group_b,
    .toggle_in);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // ********
  // Tasks
  // ********
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int t;
    @(posedge aclk);
    seed = lfsr(seed);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= seed[0];
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= 1'b1;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk(t < 60, 1);
  endtask
  task automatic rdt(input logic [7:0] a);
    int t;
    @(posedge aclk);
    seed = lfsr(seed);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= seed[0];
    for (t = 0; t < 60; t++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= 1'b1;
    end
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(t < 60, 1);
  endtask
  // Settling is two sync stages, one register and the controller's lag
  task automatic sel(input logic [1:0] m, input logic [3:0] c, input logic [3:0] e);
    @(posedge aclk);
    mode <= m;
    code <= c;
    lag <= seed[7:4];
    repeat (seed[7:4] + 8) @(posedge aclk);
    chk(sel_index, e);
    for (int o = 0; o < 5; o++) chk(threshold_out[o], exp_thr[o][e]);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(100 * 60000);
    n_errors++;
    conclude();
  end
  // ********
  // Tests
  // ********
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, mode, code, lag} = '0;
    seed = 32'h4494;
    n_errors = 0;
    checks_done = 0;
    for (i = 0; i < 80; i++) exp_thr[i / 16][i % 16] = i % 2 ? sps_pkg::THR_EVEN_RST : sps_pkg::THR_ODD_RST;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 48; i++) begin
      rdt(8'(sps_pkg::ADDR_THR_BASE + 4 * i));
      chk(rd, exp_thr[i / 16][i % 16]);
    end
    for (i = 0; i < 9; i++) begin
      rdt(ra[i]);
      chk(rd, rv[i]);
    end
    chk(sensor_b_cfg.sense, sps_pkg::S2_SENSE_RST);
    wr(sps_pkg::ADDR_S2_MULDIV, 32'h27100001, 4'hf);
    chk({sensor_b_cfg.div, sensor_b_cfg.mul}, {14'h2710, 14'h0001});
    for (i = 0; i < 5; i++) begin
      v = i == 3 ? 4 : i == 4 ? 7 : i;
      wr(sps_pkg::ADDR_S2_MISC, v, 4'hf);
      chk(sensor_b_cfg.err_mask, v[2:0]);
    end
    wr(sps_pkg::ADDR_S2_MISC, 32'h1, 4'h3);
    chk({rsp, sensor_b_cfg.err_mask}, {2'h2, 3'h7});
    rdt(8'h30);
    chk({rsp, rd}, {2'h2, 32'h0});
    $display("reset values and sensor set done");
    for (i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      // Ascending per output so a broken line falls to a smaller point
      v = 32'($signed(seed) % 3000000 + (i % 16) * 6000000 - 45000000);
      if (i == 32) v = -sps_pkg::THR_MAX;
      if (i == 47) v = sps_pkg::THR_MAX;
      wr(8'(sps_pkg::ADDR_THR_BASE + 4 * i), v, 4'hf);
      chk(rsp, 2'h0);
      exp_thr[i / 16][i % 16] = v;
    end
    wr(8'(sps_pkg::ADDR_THR_BASE + 52), sps_pkg::THR_MAX + 32'h1, 4'hf);
    chk(rsp, 2'h2);
    rdt(8'(sps_pkg::ADDR_THR_BASE + 52));
    chk(rd, exp_thr[0][13]);
    for (i = 0; i < 4; i++) begin
      wr(sps_pkg::ADDR_CTRL, 32'h100 | 32'(i % 2 + 1) | 32'((i / 2 + 1) * 4), 4'hf);
      sel(2'h0, 4'h1, 4'h1);
      sel(2'h0, 4'h0, 4'h0);
    end
    wr(sps_pkg::ADDR_CTRL, 32'h9, 4'hf);
    sel(2'h0, 4'h1, 4'h0);
    for (i = 0; i < 3; i++) begin
      wr(sps_pkg::ADDR_CTRL, 32'h0, 4'hf);
      wr(sps_pkg::ADDR_CTRL, i == 0 ? 32'h13 : i == 1 ? 32'h3c : 32'h3f, 4'hf);
      k = 0;
      sel(i == 0 ? 2'h1 : 2'h2, 4'h0, 4'h0);
      repeat (6) begin
        seed = lfsr(seed);
        k = (k + (seed[0] ? 1 : 3)) % 4;
        sel(i == 0 ? 2'h1 : 2'h2, 4'(k), 4'(k));
        rdt(sps_pkg::ADDR_ACTIVE_THR);
        chk(rd, exp_thr[0][k]);
      end
    end
    wr(sps_pkg::ADDR_CTRL, 32'h0, 4'hf);
    wr(sps_pkg::ADDR_CTRL, 32'h4c, 4'hf);
    sel(2'h3, 4'hf, 4'hf);
    repeat (10) begin
      seed = lfsr(seed);
      v = seed;
      sel(2'h3, v[3:0], v[3:0]);
    end
    $display("selection done");
    seed = lfsr(seed);
    v = seed;
    wr(sps_pkg::ADDR_DRIFT, {18'h0, v[13:0]}, 4'hf);
    chk(out_a_max_drift, v[13:0]);
    for (i = 16; i < 20; i++) begin
      wr(sps_pkg::ADDR_CTRL, 32'(i) << 16, 4'hf);
      chk(drift_active, i == 17 || i == 18);
    end
    wr(sps_pkg::ADDR_ERR_TIME, 32'h1, 4'hf);
    wr(sps_pkg::ADDR_CTRL, 32'h13, 4'hf);
    sel(2'h1, 4'h0, 4'h0);
    sel(2'h3, 4'hc, 4'h0);
    repeat (9900) @(posedge aclk);
    chk(sel_error, 1'b0);
    repeat (200) @(posedge aclk);
    chk(sel_error, 1'b1);
    mode <= 2'h1;
    code <= 4'h1;
    repeat (30) @(posedge aclk);
    chk(sel_error, 1'b1);
    rdt(sps_pkg::ADDR_STATUS);
    chk(rd[8], 1'b1);
    chk(rd[3:0], 4'h1);
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({sel_error, sel_index}, 5'h00);
    $display("drift and input error done");
    conclude();
  end
endmodule
